// file: tvr_regs.svh
// Purpose: named constants for the text video refresh and RAM access block
// Assumes: one 10 MHz clock stands in for the dot clock
// Notes:   included by the package and the design files
`ifndef TVR_REGS_SVH
`define TVR_REGS_SVH

// ==========================================================================
// dot and character timing
`define TVR_DOT_PRESET_80  4'h8
`define TVR_DOT_PRESET_40  4'h0
`define TVR_DOT_LAST       4'hF
`define TVR_SLOT_MID       2'h3
`define TVR_COL_LAST_80    7'h7F
`define TVR_COL_LAST_40    7'h3F
`define TVR_ROW_LAST       4'h9
`define TVR_LINE_LAST      5'h1F
`define TVR_VIS_LINES      5'h18
`define TVR_MAP_VISIBLE    6'h28

// ==========================================================================
// address remap and symbol classes
`define TVR_REMAP_LINE_HI  2'h3
`define TVR_DIM_LO         8'h70
`define TVR_DIM_HI         8'hBF

// ==========================================================================
// host port map
`define TVR_VID_PORT_LAST  7'h17
`define TVR_CTRL_PORT      7'h40
`define TVR_IDLE_READ      8'hFF
`define TVR_CTRL_W80       0
`define TVR_CTRL_FONT      1
`define TVR_CTRL_MIX       2
`define TVR_STAT_LBLANK    4
`define TVR_STAT_FBLANK    5

`endif

// file: tvr_pkg.sv
// Purpose: shared types for the text video refresh block
// Assumes: tvr_regs.svh holds every number
// Notes:   types only
`include "tvr_regs.svh"

package tvr_pkg;

    // ======================================================================
    // host port I/O request, one cycle per strobe
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } tvr_host_req_t;

    // ======================================================================
    // latched control write port
    typedef struct packed {
        logic mix_en;
        logic alt_font;
        logic width80;
    } tvr_ctrl_t;

    // ======================================================================
    // host access sequencer
    typedef enum logic [1:0] {
        TVR_H_IDLE  = 2'b00,
        TVR_H_EXTRA = 2'b01,
        TVR_H_SLOT  = 2'b10,
        TVR_H_RDATA = 2'b11
    } tvr_host_state_t;

endpackage

// file: tvr_video_ram.sv
// Purpose: 2K x 8 video RAM with one synchronous port
// Assumes: read data appears the cycle after the address
// Notes:   the caller time-shares the single port between slots
`timescale 1ns/100ps

module tvr_video_ram
    import tvr_pkg::*;
(
    // clock
    input  wire logic        mclk,
    // port
    input  wire logic [10:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        we,
    output logic      [7:0]  rdata
);

    // ======================================================================
    // storage
    logic [7:0] mem [0:2047];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule // tvr_video_ram

// file: tvr_text_video.sv
// Purpose: text video refresh, RAM time sharing and dot output
// Assumes: mclk is the dot clock; chargen ROM sits outside
// Notes:   host video ports stall via host_wait
//
// Summary of operation
// - RAM position from 7-bit column and 5-bit line counters.
// - 80 mode: columns above 63 fold onto lines 24-31, three groups.
// - 40 mode: remap disabled, counters address RAM directly.
// - RAM access alternates display slot and host slot at 2 MHz rate.
// - display slot latches counter address mid-slot at 4 MHz falling.
// - at end of character the RAM data is latched to chargen.
// - same moment previous slice loads shifter unless blanking.
// - shifter sends dots serially at dot clock rate in 80 mode.
// - host writes RAM via ports 0-17H, one port per line.
// - video port access gets one extra wait state.
// - low seven address bits line, upper bits column, data character.
// - host reads RAM via input ports, same addressing and slot.
// - 40 mode presets dot counter to 0, doubling character width.
// - 40 mode column counter runs 0 to 63 per line.
// - line map sees column bits chosen per mode.
// - 40 mode shifter steps only every other clock.
// - dim asserted for displayed codes 70-BF hex.
// - graphics input mixed with text, software can disable.
// - reset clears all control bits including width select.
// - software selects 40/80 columns and one of two fonts.
// - 80 mode dot counter 8 to 15, end of character, reload.
// - slices 0-9 per row; counters reset at line count 31.
`timescale 1ns/100ps
`include "tvr_regs.svh"

module tvr_text_video
    import tvr_pkg::*;
(
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          reset,
    // host port I/O
    input  wire tvr_host_req_t host_req,
    output logic               host_wait,
    output logic               host_done,
    output logic [7:0]         host_rdata,
    // character generator
    output logic [7:0]         glyph_code,
    output logic [3:0]         glyph_row,
    output logic               alternate_font_select,
    input  wire logic [7:0]    glyph_slice,
    // video
    input  wire logic          graphics_mix_input,
    output logic               video_out,
    output logic               grey_symbol_dim,
    output logic               line_blanking,
    output logic               field_blanking
);

    // ======================================================================
    // helpers
    function automatic logic [10:0] ram_addr(input logic [6:0] col,
                                             input logic [4:0] line,
                                             input logic       remap);
        if (remap && col[6]) begin
            // spare lines 24-31 hold columns 64-79, grouped by line[4:3]
            ram_addr = {`TVR_REMAP_LINE_HI, line[2:0], line[4:3],
                        col[3:0]};
        end else begin
            ram_addr = {line, col[5:0]};
        end
    endfunction

    function automatic logic is_video_port(input logic [15:0] a);
        is_video_port = (a[6:0] <= `TVR_VID_PORT_LAST);
    endfunction

    // ======================================================================
    // state
    tvr_ctrl_t       ctrl;
    tvr_ctrl_t       next_ctrl;
    logic [3:0]      dot;
    logic [3:0]      next_dot;
    logic [6:0]      col;
    logic [6:0]      next_col;
    logic [3:0]      row;
    logic [3:0]      next_row;
    logic [4:0]      line;
    logic [4:0]      next_line;
    logic            next_line_blanking;
    logic            next_field_blanking;

    tvr_host_state_t hstate;
    tvr_host_state_t next_hstate;
    logic [10:0]     haddr;
    logic [10:0]     next_haddr;
    logic [7:0]      hdata;
    logic [7:0]      next_hdata;
    logic            hwrite;
    logic            next_hwrite;
    logic            next_host_wait;
    logic            next_host_done;
    logic [7:0]      next_host_rdata;

    logic            disp_cap;
    logic            next_disp_cap;
    logic [7:0]      disp_data;
    logic [7:0]      next_disp_data;
    logic [7:0]      next_glyph_code;
    logic [3:0]      next_glyph_row;
    logic [7:0]      shifter;
    logic [7:0]      next_shifter;
    logic            half;
    logic            next_half;
    logic            dim_cur;
    logic            next_dim_cur;
    logic            next_video_out;
    logic            next_grey_symbol_dim;

    // ======================================================================
    // shared decode
    logic            eoc;
    logic            display_access_slot;
    logic            host_access_slot;
    logic            slot_mid;
    logic            disp_rd;
    logic            host_go;
    logic            blank;
    logic [6:0]      col_last;
    logic            line_end;
    logic [5:0]      map_in;
    logic [10:0]     mem_addr;
    logic            mem_we;
    logic [7:0]      mem_q;

    always_comb begin
        eoc                 = (dot == `TVR_DOT_LAST);
        display_access_slot = ~dot[2];
        host_access_slot    = dot[2];
        slot_mid            = (dot[1:0] == `TVR_SLOT_MID);
        disp_rd             = display_access_slot && slot_mid;
        host_go             = (hstate == TVR_H_SLOT) && host_access_slot
                              && slot_mid;
        blank               = line_blanking || field_blanking;
        col_last            = ctrl.width80 ? `TVR_COL_LAST_80
                                           : `TVR_COL_LAST_40;
        line_end            = eoc && (col >= col_last);
        // least significant map input toggles at the same rate in both widths
        map_in              = ctrl.width80 ? col[6:1] : col[5:0];
        mem_addr            = host_go ? haddr
                                      : ram_addr(col, line, ctrl.width80);
        mem_we              = host_go && hwrite;
    end

    tvr_video_ram u_ram (
        .mclk  (mclk),
        .addr  (mem_addr),
        .wdata (hdata),
        .we    (mem_we),
        .rdata (mem_q)
    );

    // ======================================================================
    // character, slice and line counters
    always_comb begin
        next_dot  = dot + 4'h1;
        next_col  = col;
        next_row  = row;
        next_line = line;
        if (eoc) begin
            next_dot = ctrl.width80 ? `TVR_DOT_PRESET_80
                                    : `TVR_DOT_PRESET_40;
            next_col = col + 7'h01;
        end
        if (line_end) begin
            next_col = 7'h00;
            if (line == `TVR_LINE_LAST) begin
                // trims the field; a free-running count would be too long
                next_row  = 4'h0;
                next_line = 5'h00;
            end else if (row == `TVR_ROW_LAST) begin
                next_row  = 4'h0;
                next_line = line + 5'h01;
            end else begin
                next_row = row + 4'h1;
            end
        end
        next_line_blanking  = (map_in >= `TVR_MAP_VISIBLE);
        next_field_blanking = (line >= `TVR_VIS_LINES);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            dot            <= `TVR_DOT_PRESET_40;
            col            <= 7'h00;
            row            <= 4'h0;
            line           <= 5'h00;
            line_blanking  <= 1'b1;
            field_blanking <= 1'b1;
        end else begin
            dot            <= next_dot;
            col            <= next_col;
            row            <= next_row;
            line           <= next_line;
            line_blanking  <= next_line_blanking;
            field_blanking <= next_field_blanking;
        end
    end

    // ======================================================================
    // host port sequencer and control write port
    always_comb begin
        next_ctrl       = ctrl;
        next_hstate     = hstate;
        next_haddr      = haddr;
        next_hdata      = hdata;
        next_hwrite     = hwrite;
        next_host_done  = 1'b0;
        next_host_rdata = host_rdata;
        next_host_wait  = host_wait;
        case (hstate)
            TVR_H_IDLE: begin
                if (host_req.wr || host_req.rd) begin
                    if (is_video_port(host_req.addr)) begin
                        // column from upper bits, line from low bits
                        next_haddr     = ram_addr(host_req.addr[13:7],
                                                  host_req.addr[4:0],
                                                  ctrl.width80);
                        next_hdata     = host_req.wdata;
                        next_hwrite    = host_req.wr;
                        next_hstate    = TVR_H_EXTRA;
                        next_host_wait = 1'b1;
                    end else begin
                        next_host_done = 1'b1;
                        if (host_req.addr[6:0] == `TVR_CTRL_PORT) begin
                            if (host_req.wr) begin
                                next_ctrl.width80 =
                                    host_req.wdata[`TVR_CTRL_W80];
                                next_ctrl.alt_font =
                                    host_req.wdata[`TVR_CTRL_FONT];
                                next_ctrl.mix_en =
                                    host_req.wdata[`TVR_CTRL_MIX];
                            end else begin
                                next_host_rdata = 8'h00;
                                next_host_rdata[`TVR_CTRL_W80]    =
                                    ctrl.width80;
                                next_host_rdata[`TVR_CTRL_FONT]   =
                                    ctrl.alt_font;
                                next_host_rdata[`TVR_CTRL_MIX]    =
                                    ctrl.mix_en;
                                next_host_rdata[`TVR_STAT_LBLANK] =
                                    line_blanking;
                                next_host_rdata[`TVR_STAT_FBLANK] =
                                    field_blanking;
                            end
                        end else if (host_req.rd) begin
                            next_host_rdata = `TVR_IDLE_READ;
                        end
                    end
                end
            end
            TVR_H_EXTRA: begin
                // one added wait state before the slot may be taken
                next_hstate = TVR_H_SLOT;
            end
            TVR_H_SLOT: begin
                if (host_go) begin
                    next_hstate = TVR_H_RDATA;
                end
            end
            TVR_H_RDATA: begin
                if (!hwrite) begin
                    next_host_rdata = mem_q;
                end
                next_host_done = 1'b1;
                next_host_wait = 1'b0;
                next_hstate    = TVR_H_IDLE;
            end
            default: begin
                next_hstate    = TVR_H_IDLE;
                next_host_wait = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl       <= '0;
            hstate     <= TVR_H_IDLE;
            haddr      <= 11'h000;
            hdata      <= 8'h00;
            hwrite     <= 1'b0;
            host_wait  <= 1'b0;
            host_done  <= 1'b0;
            host_rdata <= 8'h00;
        end else begin
            ctrl       <= next_ctrl;
            hstate     <= next_hstate;
            haddr      <= next_haddr;
            hdata      <= next_hdata;
            hwrite     <= next_hwrite;
            host_wait  <= next_host_wait;
            host_done  <= next_host_done;
            host_rdata <= next_host_rdata;
        end
    end

    // ======================================================================
    // refresh data path and dot shifter
    always_comb begin
        next_disp_cap        = disp_rd;
        next_disp_data       = disp_cap ? mem_q : disp_data;
        next_glyph_code      = glyph_code;
        next_glyph_row       = row;
        next_shifter         = shifter;
        next_dim_cur         = dim_cur;
        // 40 mode steps the shifter on alternate clocks only
        next_half            = ctrl.width80 ? 1'b0 : ~half;
        if (eoc) begin
            next_glyph_code = disp_data;
            // the slice on the ROM now belongs to the previous character
            next_shifter    = blank ? 8'h00 : glyph_slice;
            next_dim_cur    = !blank && (glyph_code >= `TVR_DIM_LO)
                              && (glyph_code <= `TVR_DIM_HI);
        end else if (ctrl.width80 || half) begin
            next_shifter = {shifter[6:0], 1'b0};
        end
        next_video_out       = !blank && (shifter[7]
                               || (ctrl.mix_en && graphics_mix_input));
        // blanking also masks mixed graphics
        next_grey_symbol_dim = dim_cur && !blank;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            disp_cap              <= 1'b0;
            disp_data             <= 8'h00;
            glyph_code            <= 8'h00;
            glyph_row             <= 4'h0;
            alternate_font_select <= 1'b0;
            shifter               <= 8'h00;
            half                  <= 1'b0;
            dim_cur               <= 1'b0;
            video_out             <= 1'b0;
            grey_symbol_dim       <= 1'b0;
        end else begin
            disp_cap              <= next_disp_cap;
            disp_data             <= next_disp_data;
            glyph_code            <= next_glyph_code;
            glyph_row             <= next_glyph_row;
            alternate_font_select <= ctrl.alt_font;
            shifter               <= next_shifter;
            half                  <= next_half;
            dim_cur               <= next_dim_cur;
            video_out             <= next_video_out;
            grey_symbol_dim       <= next_grey_symbol_dim;
        end
    end

endmodule // tvr_text_video

// file: tvr_host_model.sv
// Purpose: host model issuing port I/O cycles
// Assumes: one-cycle strobes; address and data held until done
// Notes:   released lines are inverted, never left at the last value
`timescale 1ns/100ps

module tvr_host_model
    import tvr_pkg::*;
(
    // clock
    input  wire logic       mclk,
    // host port
    output tvr_host_req_t   host_req,
    input  wire logic       host_wait,
    input  wire logic       host_done,
    input  wire logic [7:0] host_rdata
);
    int timeouts;

    initial begin
        host_req = '0;
        timeouts = 0;
    end

    // ======================================================================
    // one port cycle; the next may start only after done or a 20-cycle timeout
    task automatic port_cycle(input logic [15:0] addr, input logic [7:0] data,
                              input logic is_rd, output logic [7:0] rdata);
        int n;
        n = 0;
        @(posedge mclk);
        host_req <= '{addr, data, !is_rd, is_rd};
        @(posedge mclk);
        host_req.wr <= 1'b0;
        host_req.rd <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (host_done !== 1'b1 && n < 20);
        if (n == 20)
            timeouts++;
        rdata = host_rdata;
        host_req.addr  <= ~addr;
        host_req.wdata <= ~data;
    endtask
endmodule // tvr_host_model

// file: tvr_text_video_monitor.sv
// Purpose: port-level checker for the text video block
// Assumes: single clock domain, synchronous reset
// Notes:   a width change spoils the timing of one visible run only
`timescale 1ns/100ps
`include "tvr_regs.svh"

module tvr_text_video_monitor
    import tvr_pkg::*;
(
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          reset,
    // host port
    input  wire tvr_host_req_t host_req,
    input  wire logic          host_wait,
    input  wire logic          host_done,
    input  wire logic [7:0]    host_rdata,
    // character generator
    input  wire logic [7:0]    glyph_code,
    input  wire logic [3:0]    glyph_row,
    input  wire logic          alternate_font_select,
    input  wire logic [7:0]    glyph_slice,
    // video
    input  wire logic          graphics_mix_input,
    input  wire logic          video_out,
    input  wire logic          grey_symbol_dim,
    input  wire logic          line_blanking,
    input  wire logic          field_blanking
);
    logic       take;
    logic       blank_q;
    logic       tainted;
    logic       next_tainted;
    logic [9:0] vis_cnt;
    logic [9:0] next_vis_cnt;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    assign take = (host_req.wr || host_req.rd) && !host_wait;

    // ======================================================================
    // visible run length, cleared at each end of line
    always_comb begin
        next_vis_cnt = line_blanking ? 10'h000 : vis_cnt + 10'h001;
        next_tainted = tainted && !(line_blanking && !blank_q);
        if (host_req.wr && host_req.addr[6:0] == `TVR_CTRL_PORT)
            next_tainted = 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            blank_q <= 1'b1;
            tainted <= 1'b1;
            vis_cnt <= 10'h000;
        end else begin
            blank_q <= line_blanking;
            tainted <= next_tainted;
            vis_cnt <= next_vis_cnt;
        end
    end

    // ======================================================================
    // host port
    done_pulse_a: assert property (
        host_done |=> !host_done) else $error("done longer than one cycle");
    video_wait_a: assert property (
        take && host_req.addr[6:0] <= `TVR_VID_PORT_LAST |=>
        (host_wait && !host_done) [*2] ##[1:12] host_done)
        else $error("video port access timing wrong");
    ctrl_done_a: assert property (
        take && host_req.addr[6:0] == `TVR_CTRL_PORT |=> host_done && !host_wait)
        else $error("control port access not done next cycle");
    wait_release_a: assert property (
        $fell(host_wait) |-> host_done) else $error("wait dropped without done");
    rdata_hold_a: assert property (
        !host_done |-> $stable(host_rdata)) else $error("read data moved");

    // ======================================================================
    // video timing
    blank_video_a: assert property (
        line_blanking [*3] |-> !video_out)
        else $error("video not background while blanking");
    blank_dim_a: assert property (
        line_blanking [*3] |-> !grey_symbol_dim) else $error("dim in blanking");
    code_hold_a: assert property (
        $changed(glyph_code) |=> $stable(glyph_code) [*7])
        else $error("character code changed too soon");
    row_step_a: assert property (
        $changed(glyph_row) |-> glyph_row == 4'h0 ||
        (glyph_row == $past(glyph_row) + 4'h1 && glyph_row <= `TVR_ROW_LAST))
        else $error("row count stepped wrongly");
    line_visible_a: assert property (
        line_blanking && !blank_q && !tainted |-> vis_cnt == 10'h280)
        else $error("visible line length wrong");
endmodule // tvr_text_video_monitor

bind tvr_text_video tvr_text_video_monitor i_mon (
    .mclk(mclk), .reset(reset), .host_req(host_req), .host_wait(host_wait),
    .host_done(host_done), .host_rdata(host_rdata), .glyph_code(glyph_code),
    .glyph_row(glyph_row), .alternate_font_select(alternate_font_select),
    .glyph_slice(glyph_slice), .graphics_mix_input(graphics_mix_input),
    .video_out(video_out), .grey_symbol_dim(grey_symbol_dim),
    .line_blanking(line_blanking), .field_blanking(field_blanking));

// file: tvr_text_video_tb_top.sv
// Purpose: self-checking bench for the text video block
// Assumes: glyph ROM gives the code, inverted for the other font
// Notes:   display passes restart the field by reset to stay on line 0
`timescale 1ns/100ps
`include "tvr_regs.svh"

module tvr_text_video_tb_top;
    import tvr_pkg::*;

    localparam logic [15:0] CTRL_A = {9'h000, `TVR_CTRL_PORT};

    logic          mclk;
    logic          reset;
    logic          graphics_mix_input;
    logic [7:0]    glyph_slice;
    tvr_host_req_t host_req;
    logic          host_wait;
    logic          host_done;
    logic [7:0]    host_rdata;
    logic [7:0]    glyph_code;
    logic [3:0]    glyph_row;
    logic          alternate_font_select;
    logic          video_out;
    logic          grey_symbol_dim;
    logic          line_blanking;
    logic          field_blanking;
    logic [7:0]    rd;
    int            mismatches;
    int            checked;
    int            cycles;

    tvr_text_video i_dut (
        .mclk(mclk), .reset(reset), .host_req(host_req),
        .host_wait(host_wait), .host_done(host_done), .host_rdata(host_rdata),
        .glyph_code(glyph_code), .glyph_row(glyph_row),
        .alternate_font_select(alternate_font_select),
        .glyph_slice(glyph_slice), .graphics_mix_input(graphics_mix_input),
        .video_out(video_out), .grey_symbol_dim(grey_symbol_dim),
        .line_blanking(line_blanking), .field_blanking(field_blanking));
    tvr_host_model i_host (
        .mclk(mclk), .host_req(host_req), .host_wait(host_wait),
        .host_done(host_done), .host_rdata(host_rdata));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // registered ROM: the slice is loaded the cycle after the code
    always @(posedge mclk)
        glyph_slice <= alternate_font_select ? ~glyph_code : glyph_code;

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            give_verdict();
        end
    end

    // ======================================================================
    // helpers
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic cmp_count(input int got, input int exp);
        checked++;
        if (got != exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_host.port_cycle(a, d, 1'b0, rd);
    endtask
    task automatic rdp(input logic [15:0] a);
        i_host.port_cycle(a, 8'h00, 1'b1, rd);
    endtask
    function automatic logic [15:0] vaddr(input logic [4:0] ln,
                                          input logic [6:0] col);
        return {2'b00, col, 2'b00, ln};
    endfunction
    task automatic wait_blank(input logic lvl);
        int n;
        n = 0;
        while (line_blanking !== lvl && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        if (n == 3000)
            mismatches++;
    endtask

    // ======================================================================
    // scenarios
    task automatic test_ctrl();
        rdp(CTRL_A);
        cmp_byte(rd & 8'h07, 8'h00);
        wr(CTRL_A, 8'h07);
        rdp(CTRL_A);
        cmp_byte(rd & 8'h07, 8'h07);
        cmp_byte({7'h00, alternate_font_select}, 8'h01);
        wr(CTRL_A, 8'h00);
        wr(16'h0018, 8'h3C);
        rdp(16'h0018);
        cmp_byte(rd, `TVR_IDLE_READ);
    endtask

    task automatic test_ram_map();
        wr(vaddr(5'h05, 7'h00), 8'hA1);
        rdp(vaddr(5'h05, 7'h40));
        cmp_byte(rd, 8'hA1);
        wr(CTRL_A, 8'h01);
        for (int i = 0; i < 24; i++)
            wr(vaddr(i[4:0], {3'h4, i[3:0]}), 8'h80 + i[7:0]);
        for (int i = 0; i < 24; i++) begin
            rdp(vaddr(i[4:0], {3'h4, i[3:0]}));
            cmp_byte(rd, 8'h80 + i[7:0]);
        end
        rdp(vaddr(5'h05, 7'h00));
        cmp_byte(rd, 8'hA1);
        wr(CTRL_A, 8'h00);
    endtask

    // fill line 0, then count dots over one character period mid-line
    task automatic test_display(input logic [7:0] code, input logic [7:0] ctl,
                                input logic gfx, input int win, input int ones,
                                input logic dim);
        int n;
        n = 0;
        @(posedge mclk);
        reset <= 1'b1;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        for (int c = 0; c < 64; c++)
            wr(vaddr(5'h00, c[6:0]), code);
        wr(CTRL_A, ctl);
        graphics_mix_input <= gfx;
        wait_blank(1'b1);
        wait_blank(1'b0);
        wait_blank(1'b1);
        wait_blank(1'b0);
        repeat (320) @(posedge mclk);
        repeat (win) begin
            @(posedge mclk);
            n += int'(video_out === 1'b1);
        end
        cmp_count(n, ones);
        cmp_byte({7'h00, grey_symbol_dim}, {7'h00, dim});
        cmp_byte({7'h00, field_blanking}, 8'h00);
        graphics_mix_input <= 1'b0;
    endtask

    task automatic give_verdict();
        mismatches += i_host.timeouts;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        graphics_mix_input = 1'b0;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        test_ctrl();
        test_ram_map();
        test_display(8'h6F, 8'h00, 1'b0, 16, 12, 1'b0);
        test_display(8'h70, 8'h00, 1'b1, 16, 6, 1'b1);
        test_display(8'hBF, 8'h00, 1'b0, 16, 14, 1'b1);
        test_display(8'hC0, 8'h03, 1'b0, 8, 6, 1'b0);
        test_display(8'hA5, 8'h04, 1'b1, 16, 16, 1'b1);
        give_verdict();
    end
endmodule // tvr_text_video_tb_top
